/* rtl/dac_latch_pkg.sv */
// Purpose: Constants for the serial converter input latch.
// Assumes: Link clock sampled by sys_clk_i at 40 MHz.
// Notes:   Shared by the top module and its edge detector.
package dac_latch_pkg;
   localparam int unsigned WIDE_BITS   = 16;
   localparam int unsigned NARROW_BITS = 14;
   localparam int unsigned SHIFT_BITS  = 16;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [15:0] CODE_RESET  = 16'h0000;
   localparam int unsigned SYNC_STAGES = 2;
endpackage

/* rtl/link_edges_if.sv */
`timescale 1ns/100ps
// Purpose: Carries synchronised link levels and edge pulses.
// Assumes: Single clock domain sys_clk_i.
// Notes:   Filled by link_sampler, read by the top.
interface link_edges_if;
   logic data_lvl;
   logic sclk_rise;
   logic sel_low;
   logic sel_rise;
   modport src (output data_lvl, output sclk_rise, output sel_low, output sel_rise);
   modport dst (input data_lvl, input sclk_rise, input sel_low, input sel_rise);
endinterface

/* rtl/link_sampler.sv */
`timescale 1ns/100ps
// Purpose: Synchronises the three host wires and finds the clock and select rising edges.
// Assumes: Link clock much slower than sys_clk_i.
// Notes:   Edges are found only after the second flop.
module link_sampler
   import dac_latch_pkg::*;
(
   input  wire logic      sys_clk_i,
   input  wire logic      nrst_i,
   input  wire logic      serial_data_in_i,
   input  wire logic      sclk_i,
   input  wire logic      sel_n_i,
   link_edges_if.src      edges
);
   import dac_latch_pkg::*;

   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic [2:0] prev;
   } samp_state_t;

   samp_state_t st_r;
   samp_state_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = {sel_n_i, sclk_i, serial_data_in_i};
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
   end

   // Chip select idles high so its flops reset high
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '{meta: 3'h4, sync: 3'h4, prev: 3'h4};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign edges.data_lvl  = st_r.sync[0];
   assign edges.sclk_rise = st_r.sync[1] & ~st_r.prev[1];
   assign edges.sel_low   = ~st_r.sync[2];
   assign edges.sel_rise  = st_r.sync[2] & ~st_r.prev[2];
endmodule

/* rtl/serial_dac_input_latch.sv */
`timescale 1ns/100ps
// Purpose: Serial input shift register and double-buffered converter code.
// Assumes: Host drives all three wires, holds clock during the strobe.
// Notes:   Code words leave through a two-entry buffer with valid/ready.
module serial_dac_input_latch
   import dac_latch_pkg::*;
#(
   parameter int unsigned CODE_BITS = dac_latch_pkg::WIDE_BITS
)
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 nrst_i,
   input  wire logic                 serial_data_in_i,
   input  wire logic                 sclk_i,
   input  wire logic                 sel_n_i,
   output logic [CODE_BITS-1:0]      dac_code_o,
   output logic [CODE_BITS-1:0]      word_data_o,
   output logic                      word_valid_o,
   input  wire logic                 word_ready_i,
   output logic                      word_drop_o
);
   import dac_latch_pkg::*;

   // Two-entry buffer between strobe and the word consumer
   typedef struct packed {
      logic [SHIFT_BITS-1:0]  shift;
      logic [CODE_BITS-1:0]   code;
      logic [CODE_BITS-1:0]   buf0;
      logic [CODE_BITS-1:0]   buf1;
      logic [1:0]             count;
      logic                   drop;
   } latch_state_t;

   latch_state_t st_r;
   latch_state_t st_nxt;
   link_edges_if edges();

   link_sampler u_sampler (
      .sys_clk_i        (sys_clk_i),
      .nrst_i           (nrst_i),
      .serial_data_in_i (serial_data_in_i),
      .sclk_i           (sclk_i),
      .sel_n_i          (sel_n_i),
      .edges            (edges)
   );

   logic push;
   logic pop;

   assign push = edges.sel_rise;
   assign pop  = word_ready_i & (st_r.count != 2'd0);

   always_comb begin
      st_nxt      = st_r;
      st_nxt.drop = 1'b0;
      // Shift only with chip select low; MSB first, oldest bit falls out
      if (edges.sel_low && edges.sclk_rise) begin
         st_nxt.shift = {st_r.shift[SHIFT_BITS-2:0], edges.data_lvl};
      end
      // Strobe loads the last CODE_BITS bits; code holds otherwise
      if (edges.sel_rise) begin
         st_nxt.code = st_r.shift[CODE_BITS-1:0];
      end
      // Buffer pop then push; a full buffer with no pop drops the word
      if (pop) begin
         st_nxt.buf0  = st_r.buf1;
         st_nxt.count = st_r.count - 2'd1;
      end
      if (push) begin
         if (st_r.count == 2'd2 && !pop) begin
            st_nxt.drop = 1'b1;
         end else if (st_nxt.count == 2'd0) begin
            st_nxt.buf0  = st_r.shift[CODE_BITS-1:0];
            st_nxt.count = 2'd1;
         end else begin
            st_nxt.buf1  = st_r.shift[CODE_BITS-1:0];
            st_nxt.count = 2'd2;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r.shift <= SHIFT_RESET;
         st_r.code  <= CODE_RESET[CODE_BITS-1:0];
         st_r.buf0  <= '0;
         st_r.buf1  <= '0;
         st_r.count <= 2'd0;
         st_r.drop  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Straight binary code straight out of the register
   assign dac_code_o   = st_r.code;
   assign word_data_o  = st_r.buf0;
   assign word_valid_o = (st_r.count != 2'd0);
   assign word_drop_o  = st_r.drop;
endmodule

/* tb/host_serial_model.sv */
// Purpose: Host serial master model.
// Assumes: 200 ns link clock, idle low.
// Notes:   Frames carry 8 surplus leading bits.
`timescale 1ns/100ps
module host_serial_model (
   output logic sdi_o = 1'b0,
   output logic sclk_o = 1'b0,
   output logic sel_n_o = 1'b1
);
   task automatic send(input logic [23:0] w);
      #100 sclk_o = 1'b1;
      #100 sclk_o = 1'b0;
      sel_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi_o = w[i];
         #100 sclk_o = 1'b1;
         #100 sclk_o = 1'b0;
      end
      #100 sel_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #300;
   endtask
endmodule

/* tb/serial_dac_input_latch_properties.sv */
// Purpose: Port checks of the latch.
// Assumes: Strobe seen three samples after pin rise.
// Notes:   Bound to the top.
`timescale 1ns/100ps
module dac_latch_checker #(parameter int unsigned CODE_BITS = 16) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic sel_n_i,
   input wire logic [CODE_BITS-1:0] dac_code_o,
   input wire logic [CODE_BITS-1:0] word_data_o,
   input wire logic word_valid_o,
   input wire logic word_ready_i,
   input wire logic word_drop_o
);
   logic [3:0] s_r;
   always_ff @(posedge sys_clk_i) s_r <= {s_r[2:0], sel_n_i};
   wire stb = s_r[2] & ~s_r[3];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   a_reset_zero: assert property (!$past(nrst_i) |-> dac_code_o == '0 && !word_valid_o) else $error("dirty");
   a_code_cause: assert property ($changed(dac_code_o) |-> stb) else $error("moved");
   a_code_word: assert property ($rose(word_valid_o) |-> word_data_o == dac_code_o) else $error("differs");
   a_valid_strobe: assert property (stb |-> word_valid_o) else $error("no word");
   a_valid_hold: assert property (word_valid_o && !word_ready_i |=> word_valid_o) else $error("lost");
   a_data_hold: assert property (word_valid_o && !word_ready_i |=> $stable(word_data_o)) else $error("data");
   a_drop_cause: assert property (word_drop_o |-> stb && $past(word_valid_o)) else $error("drop");
   a_drop_pulse: assert property (word_drop_o |=> !word_drop_o) else $error("long drop");
endmodule
bind serial_dac_input_latch dac_latch_checker #(.CODE_BITS(CODE_BITS)) u_dac_latch_checker (.sys_clk_i, .nrst_i,
   .sel_n_i, .dac_code_o, .word_data_o, .word_valid_o, .word_ready_i, .word_drop_o);

/* tb/serial_dac_input_latch_tb_top.sv */
// Purpose: Bench of the latch.
// Assumes: 40 MHz clock, 200 ns link clock.
// Notes:   One stall fills the buffer.
`timescale 1ns/100ps
module serial_dac_input_latch_tb_top;
   logic sys_clk_i = 1'b0, nrst_i = 1'b0, word_ready_i = 1'b0, stall = 1'b0;
   logic serial_data_in, sclk, sel_n, word_valid_o, word_drop_o;
   logic [15:0] dac_code_o, word_data_o, q[$];
   logic [31:0] lfsr = 32'h4384E00B;
   int n_errors = 0, check_count = 0, drops = 0, exp_drops = 0;
   serial_dac_input_latch #(.CODE_BITS(16)) u_serial_dac_input_latch (.sys_clk_i, .nrst_i, .serial_data_in_i(serial_data_in),
      .sclk_i(sclk), .sel_n_i(sel_n), .dac_code_o, .word_data_o, .word_valid_o, .word_ready_i, .word_drop_o);
   host_serial_model u_host_serial_model (.sdi_o(serial_data_in), .sclk_o(sclk), .sel_n_o(sel_n));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic frame(input logic [23:0] w);
      if (q.size() < 2) q.push_back(w[15:0]);
      else exp_drops++;
      u_host_serial_model.send(w);
      check("code", dac_code_o, w[15:0]);
   endtask
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   // Settled mid-cycle: what the next rising edge will take
   always @(negedge sys_clk_i) begin
      if (word_drop_o === 1'b1) drops++;
      if ((word_valid_o & word_ready_i) === 1'b1) check("word", word_data_o, q.pop_front());
   end
   always @(posedge sys_clk_i) begin
      #2 lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      word_ready_i = !stall && lfsr[0];
   end
   initial begin
      repeat (16) @(posedge sys_clk_i);
      #2 nrst_i = 1'b1;
      check("reset", dac_code_o, 16'h0000);
      frame(24'h5AFFFF);
      frame(24'hA50000);
      repeat (10) frame(lfsr[23:0]);
      stall = 1'b1;
      repeat (3) frame(lfsr[23:0]);
      stall = 1'b0;
      for (int i = 0; i < 99 && q.size() > 0; i++) @(posedge sys_clk_i);
      if (q.size() > 0) n_errors++;
      check("drops", 16'(drops), 16'(exp_drops));
      final_report();
   end
endmodule
